/* File: common/ptrc_pkg.sv */
/*
 * package of the program trace ram controller: register offsets, field
 * positions, reset values and sizes shared by the design files.
 * assumes a 32-bit apb register bus and a 32-bit word-wide ram.
 */
package ptrc_pkg;
   // ****************************************************************
   // register offsets (byte addresses on apb)
   // ****************************************************************
   localparam logic [7:0] REG_CTRL = 8'h00;    // enable, start, stop
   localparam logic [7:0] REG_BASE = 8'h04;    // trace region base packet
   localparam logic [7:0] REG_LIMIT = 8'h08;   // trace region last packet
   localparam logic [7:0] REG_POS = 8'h0C;     // write pointer (packet)
   localparam logic [7:0] REG_CMP0_ADDR = 8'h10;
   localparam logic [7:0] REG_CMP0_DATA = 8'h14;
   localparam logic [7:0] REG_CMP1_ADDR = 8'h18;
   localparam logic [7:0] REG_CMP1_DATA = 8'h1C;
   localparam logic [7:0] REG_CMP_CFG = 8'h20;
   localparam logic [7:0] REG_STATUS = 8'h24;
   // ****************************************************************
   // control field positions
   // ****************************************************************
   localparam int CTRL_EN_BIT = 0;      // tracing active
   localparam int CTRL_START_BIT = 1;   // write 1: start (pulse)
   localparam int CTRL_STOP_BIT = 2;    // write 1: stop (pulse)
   // comparator config: per comparator 4 bits at 4*n
   localparam int CFG_EN_BIT = 0;       // comparator enabled
   localparam int CFG_DATA_BIT = 1;     // also match data value
   localparam int CFG_START_BIT = 2;    // hit starts trace
   localparam int CFG_STOP_BIT = 3;     // hit stops trace
   localparam int CFG_FIELD_W = 4;
   // ****************************************************************
   // sizes and reset values
   // ****************************************************************
   localparam int RAM_AW = 10;          // words of system ram, log2
   localparam int NUM_CMP = 2;
   localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
endpackage

/* File: rtl/ptrc_ram.sv */
/*
 * single-port word ram with byte enables; read data comes from a
 * register one cycle after the request.
 * assumes one request per cycle at most; no reset on the array.
 */
`timescale 1ns/10ps
`default_nettype none
module ptrc_ram #(
   parameter int AW = 10
) (
   // clock
   input wire logic pclk,
   // access port
   input wire logic en,
   input wire logic [3:0] we,
   input wire logic [AW-1:0] addr,
   input wire logic [31:0] wdata,
   output logic [31:0] rdata
);
   logic [31:0] mem_q [0:(1<<AW)-1];

   // byte-wise write, registered read
   always_ff @(posedge pclk) begin
      if (en) begin
         for (int b = 0; b < 4; b++) begin
            if (we[b]) begin
               mem_q[addr][8*b +: 8] <= wdata[8*b +: 8];
            end
         end
         rdata <= mem_q[addr];
      end
   end
endmodule // ptrc_ram
`default_nettype wire

/* File: rtl/ptrc_top.sv */
/*
 * program trace ram controller: ahb-lite slave onto system ram, a trace
 * recorder writing 64-bit change-of-flow packets, apb registers and a
 * watchpoint unit.
 * assumes the core trace port and the ahb bus share pclk.
 */
`timescale 1ns/10ps
`default_nettype none
module ptrc_top #(
   parameter int AW = ptrc_pkg::RAM_AW
) (
   // clock and reset, the only domain
   input wire logic pclk,
   input wire logic presetn,
   // apb register port
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // ahb-lite system ram slave
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] haddr,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // core execution trace port
   input wire logic exec_addr_load_enable,
   input wire logic [30:0] exec_instr_addr,
   input wire logic exec_addr_sequential,
   input wire logic atomic,
   // core bus as observed by the watchpoints
   input wire logic cpu_bus_valid,
   input wire logic [31:0] cpu_bus_addr,
   input wire logic [31:0] cpu_bus_data,
   // recording state
   output logic trace_active
);
   // ****************************************************************
   // registers
   // ****************************************************************
   logic en_q;
   logic [AW-2:0] base_q;   // region in packet (doubleword) units
   logic [AW-2:0] limit_q;
   logic [AW-2:0] pos_q;
   logic [63:0] cmp_addr_q;
   logic [63:0] cmp_data_q;
   logic [7:0] cmp_cfg_q;
   logic first_q;           // next packet carries the start flag
   logic wrapped_q;         // pointer has wrapped at least once
   logic start_trig;
   logic stop_trig;

   ptrc_watch #(.NCMP(ptrc_pkg::NUM_CMP)) u_watch (
      .pclk(pclk),
      .presetn(presetn),
      .bus_valid(cpu_bus_valid),
      .bus_addr(cpu_bus_addr),
      .bus_data(cpu_bus_data),
      .cmp_addr(cmp_addr_q),
      .cmp_data(cmp_data_q),
      .cmp_cfg(cmp_cfg_q),
      .trace_start_trigger(start_trig),
      .trace_stop_trigger(stop_trig)
   );

   // ****************************************************************
   // apb slave, one access cycle, never waits
   // ****************************************************************
   wire apb_wr = psel && penable && pwrite;
   wire apb_rd = psel && !penable && !pwrite;
   wire sw_start = apb_wr && paddr == ptrc_pkg::REG_CTRL
      && pwdata[ptrc_pkg::CTRL_START_BIT];
   wire sw_stop = apb_wr && paddr == ptrc_pkg::REG_CTRL
      && pwdata[ptrc_pkg::CTRL_STOP_BIT];
   wire go = sw_start || start_trig;
   wire halt = sw_stop || stop_trig;
   wire known = paddr <= ptrc_pkg::REG_STATUS && paddr[1:0] == 2'b00;

   logic [31:0] rd_mux;
   always_comb begin
      case (paddr)
         ptrc_pkg::REG_CTRL: rd_mux = {31'h0, en_q};
         ptrc_pkg::REG_BASE: rd_mux = 32'(base_q);
         ptrc_pkg::REG_LIMIT: rd_mux = 32'(limit_q);
         ptrc_pkg::REG_POS: rd_mux = 32'(pos_q);
         ptrc_pkg::REG_CMP0_ADDR: rd_mux = cmp_addr_q[31:0];
         ptrc_pkg::REG_CMP0_DATA: rd_mux = cmp_data_q[31:0];
         ptrc_pkg::REG_CMP1_ADDR: rd_mux = cmp_addr_q[63:32];
         ptrc_pkg::REG_CMP1_DATA: rd_mux = cmp_data_q[63:32];
         ptrc_pkg::REG_CMP_CFG: rd_mux = {24'h0, cmp_cfg_q};
         ptrc_pkg::REG_STATUS: rd_mux = {30'h0, wrapped_q, first_q};
         default: rd_mux = ptrc_pkg::RESET_ZERO;
      endcase
   end

   // read data latched in setup, error flagged for unmapped offsets
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= ptrc_pkg::RESET_ZERO;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         if (apb_rd) begin
            prdata <= rd_mux;
         end
         pready <= psel && !penable;
         pslverr <= psel && !penable && !known;
      end
   end

   // configuration writes; trace region set by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base_q <= '0;
         limit_q <= '1;
         cmp_addr_q <= '0;
         cmp_data_q <= '0;
         cmp_cfg_q <= '0;
      end else if (apb_wr) begin
         case (paddr)
            ptrc_pkg::REG_BASE: base_q <= pwdata[AW-2:0];
            ptrc_pkg::REG_LIMIT: limit_q <= pwdata[AW-2:0];
            ptrc_pkg::REG_CMP0_ADDR: cmp_addr_q[31:0] <= pwdata;
            ptrc_pkg::REG_CMP0_DATA: cmp_data_q[31:0] <= pwdata;
            ptrc_pkg::REG_CMP1_ADDR: cmp_addr_q[63:32] <= pwdata;
            ptrc_pkg::REG_CMP1_DATA: cmp_data_q[63:32] <= pwdata;
            ptrc_pkg::REG_CMP_CFG: cmp_cfg_q <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // trace recorder
   // ****************************************************************
   // the previous execute address is the branch source; a load with
   // the sequential flag low marks a change of flow on any instruction
   logic [30:0] prev_q;
   logic [63:0] pkt_q;
   logic pkt_pend_q;   // low word pending
   logic hi_pend_q;    // high word pending
   logic [AW-2:0] slot_q;
   wire flow = en_q && exec_addr_load_enable && !exec_addr_sequential;
   wire wr_lo = pkt_pend_q;
   wire wr_hi = hi_pend_q;
   wire trace_busy = wr_lo || wr_hi;
   // pointer steps one packet, back to base after limit
   wire [AW-2:0] pos_nx = (pos_q == limit_q) ? base_q
      : (AW-1)'(pos_q + 1'b1);

   // previous address tracking and packet capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= '0;
         pkt_q <= '0;
         pkt_pend_q <= 1'b0;
         hi_pend_q <= 1'b0;
         slot_q <= '0;
      end else begin
         if (exec_addr_load_enable) begin
            prev_q <= exec_instr_addr;
         end
         // source always bits 31:1 with atomic flag, destination with
         // start flag; exception return yields two core-side changes of
         // flow, each captured the same way
         if (flow) begin
            pkt_q <= {exec_instr_addr, first_q,
               prev_q, atomic};
            slot_q <= pos_q;
         end
         pkt_pend_q <= flow;
         hi_pend_q <= pkt_pend_q;
      end
   end

   // recording state and start flag; stop wins over start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= 1'b0;
         first_q <= 1'b0;
         pos_q <= '0;
         wrapped_q <= 1'b0;
         trace_active <= 1'b0;
      end else begin
         if (halt) begin
            en_q <= 1'b0;
         end else if (go) begin
            en_q <= 1'b1;
         end
         if (go && !halt) begin
            first_q <= 1'b1;
         end else if (flow) begin
            first_q <= 1'b0;
         end
         if (apb_wr && paddr == ptrc_pkg::REG_POS) begin
            pos_q <= pwdata[AW-2:0];
         end else if (flow) begin
            pos_q <= pos_nx;
         end
         if (flow && pos_q == limit_q) begin
            wrapped_q <= 1'b1;
         end else if (apb_wr && paddr == ptrc_pkg::REG_POS) begin
            wrapped_q <= 1'b0;
         end
         trace_active <= halt ? 1'b0 : (go ? 1'b1 : en_q);
      end
   end

   // ****************************************************************
   // ahb slave with two-deep address hold
   // ****************************************************************
   // a transfer whose data phase meets a trace write is parked; the
   // second address phase may be accepted meanwhile, then hready drops
   logic [AW-1:0] a0_q, a1_q;
   logic w0_q, w1_q, v0_q, v1_q;
   logic [3:0] be0_q, be1_q;
   logic dph_q;         // data phase of v0 owed to the master
   logic [31:0] wd_q;   // held write data beat
   logic wd_v_q;
   wire ahb_req = hsel && htrans[1] && hreadyout;
   wire [3:0] be_new = hsize == 3'd0 ? 4'b0001 << haddr[1:0]
      : hsize == 3'd1 ? (haddr[1] ? 4'b1100 : 4'b0011) : 4'b1111;
   wire [31:0] cur_wd = wd_v_q ? wd_q : hwdata;
   // a queued access goes to the ram when no trace word needs it
   wire bus_go = v0_q && !trace_busy && (!w0_q || wd_v_q || dph_q);
   wire [AW-1:0] t_addr = {slot_q, wr_hi};
   wire ram_en = trace_busy || bus_go;
   wire [3:0] ram_we = trace_busy ? 4'hF
      : (w0_q ? be0_q : 4'h0);
   wire [AW-1:0] ram_addr = trace_busy ? t_addr : a0_q;
   wire [31:0] ram_wd = wr_hi ? pkt_q[63:32]
      : (wr_lo ? pkt_q[31:0] : cur_wd);
   logic rd_ret_q;
   logic [31:0] ram_rd;

   ptrc_ram #(.AW(AW)) u_ram (
      .pclk(pclk),
      .en(ram_en),
      .we(ram_we),
      .addr(ram_addr),
      .wdata(ram_wd),
      .rdata(ram_rd)
   );

   // queue of address phases; shift after each served access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         v0_q <= 1'b0; v1_q <= 1'b0; w0_q <= 1'b0; w1_q <= 1'b0;
         a0_q <= '0; a1_q <= '0; be0_q <= '0; be1_q <= '0;
         dph_q <= 1'b0; wd_q <= '0; wd_v_q <= 1'b0;
      end else begin
         // write data of the parked write captured once it is on hwdata
         if (v0_q && w0_q && dph_q && !bus_go && !wd_v_q) begin
            wd_q <= hwdata;
            wd_v_q <= 1'b1;
         end else if (bus_go) begin
            wd_v_q <= 1'b0;
         end
         if (bus_go) begin
            v0_q <= v1_q || ahb_req;
            w0_q <= v1_q ? w1_q : hwrite;
            a0_q <= v1_q ? a1_q : haddr[AW+1:2];
            be0_q <= v1_q ? be1_q : be_new;
            v1_q <= v1_q && ahb_req;
            w1_q <= hwrite;
            a1_q <= haddr[AW+1:2];
            be1_q <= be_new;
            dph_q <= v1_q || ahb_req;
         end else begin
            if (ahb_req && !v0_q) begin
               v0_q <= 1'b1; w0_q <= hwrite;
               a0_q <= haddr[AW+1:2]; be0_q <= be_new;
            end else if (ahb_req) begin
               v1_q <= 1'b1; w1_q <= hwrite;
               a1_q <= haddr[AW+1:2]; be1_q <= be_new;
            end
            dph_q <= v0_q || ahb_req;
         end
      end
   end

   // response: ready while the queue has room and no read or trace write is in progress, data a cycle after ram
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= '0;
         rd_ret_q <= 1'b0;
      end else begin
         rd_ret_q <= bus_go && !w0_q;
         if (rd_ret_q) begin
            hrdata <= ram_rd;
         end
         // zero waits while the queue drains each cycle
         // a read just taken must wait: the ram and hrdata both register
         hreadyout <= !(v1_q || (v0_q && !bus_go && ahb_req)
            || (ahb_req && !hwrite)
            || (bus_go && !w0_q) || trace_busy);
      end
   end
endmodule // ptrc_top
`default_nettype wire

/* File: rtl/ptrc_watch.sv */
/*
 * watchpoint unit: comparators on the processor address and data bus
 * raising one-cycle start and stop trigger pulses.
 * assumes bus address and data are sampled in the same cycle.
 */
`timescale 1ns/10ps
`default_nettype none
module ptrc_watch #(
   parameter int NCMP = 2
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // observed processor bus
   input wire logic bus_valid,
   input wire logic [31:0] bus_addr,
   input wire logic [31:0] bus_data,
   // configuration
   input wire logic [NCMP*32-1:0] cmp_addr,
   input wire logic [NCMP*32-1:0] cmp_data,
   input wire logic [NCMP*4-1:0] cmp_cfg,
   // triggers
   output logic trace_start_trigger,
   output logic trace_stop_trigger
);
   logic [NCMP-1:0] hit;
   logic [NCMP-1:0] start_hit;
   logic [NCMP-1:0] stop_hit;

   // one comparator per entry: address alone or address plus data
   for (genvar i = 0; i < NCMP; i++) begin : g_cmp
      wire [3:0] cfg = cmp_cfg[4*i +: 4];
      wire a_eq = bus_addr == cmp_addr[32*i +: 32];
      wire d_eq = bus_data == cmp_data[32*i +: 32];
      assign hit[i] = bus_valid && cfg[ptrc_pkg::CFG_EN_BIT] && a_eq
         && (d_eq || !cfg[ptrc_pkg::CFG_DATA_BIT]);
      assign start_hit[i] = hit[i] && cfg[ptrc_pkg::CFG_START_BIT];
      assign stop_hit[i] = hit[i] && cfg[ptrc_pkg::CFG_STOP_BIT];
   end

   // registered trigger pulses towards the recorder
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trace_start_trigger <= 1'b0;
         trace_stop_trigger <= 1'b0;
      end else begin
         trace_start_trigger <= |start_hit;
         trace_stop_trigger <= |stop_hit;
      end
   end
endmodule // ptrc_watch
`default_nettype wire

/* File: tb/ptrc_assertions.sv */
/* checker for the trace ram controller: apb answer timing, error
   replies, ahb response and wait bound, start of recording.
   assumes it is bound to ptrc_top and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module ptrc_assertions (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb port
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // ahb answer and state
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic trace_active
);
   // ****************************************************************
   // properties
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // offsets past the last register or off a word boundary
   wire bad_off = (paddr > 8'h24) || (paddr[1:0] != 2'h0);
   // start without stop, since stop wins when both are written
   wire start_wr = psel && penable && pready && pwrite && paddr == 8'h00
      && pwdata[1] && !pwdata[2];
   sequence setup_s; psel && !penable; endsequence
   sequence access_s; psel && penable && pready; endsequence
   sequence stall_s; $fell(hreadyout); endsequence
   chk_apb_answer: assert property (setup_s |=> access_s)
      else $error("apb access not answered one cycle after setup");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   chk_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside an access cycle");
   chk_err_unmapped: assert property (pready && bad_off |-> pslverr)
      else $error("unmapped offset not refused");
   chk_err_mapped: assert property (pready && !bad_off |-> !pslverr)
      else $error("mapped offset refused");
   chk_bad_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   chk_ahb_okay: assert property (hresp == 1'h0)
      else $error("ahb error response");
   chk_wait_bound: assert property (stall_s |-> ##[0:6] hreadyout)
      else $error("ahb stall too long");
   chk_start_active: assert property (start_wr |=> ##[0:2] trace_active)
      else $error("start write did not begin recording");
endmodule // ptrc_assertions
`default_nettype wire

/* File: tb/ptrc_core_model.sv */
/* processor trace port model: sequential execution with branches on
   command from the bench.
   assumes the bench spaces branches at least two cycles apart. */
`timescale 1ns/10ps
`default_nettype none
module ptrc_core_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // branch command
   input wire logic jump,
   input wire logic [30:0] jump_to,
   input wire logic jump_atomic,
   // trace port
   output logic exec_addr_load_enable,
   output logic [30:0] exec_instr_addr,
   output logic exec_addr_sequential,
   output logic atomic
);
   // ****************************************************************
   // execute stage
   // ****************************************************************
   // one instruction a cycle, halfword steps in pc>>1 units
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exec_addr_load_enable <= 1'h0;
         exec_instr_addr <= 31'h0000_0800;
         exec_addr_sequential <= 1'h1;
         atomic <= 1'h0;
      end else begin
         exec_addr_load_enable <= 1'h1;
         exec_addr_sequential <= !jump;
         atomic <= jump && jump_atomic;
         exec_instr_addr <= jump ? jump_to : exec_instr_addr + 31'h1;
      end
   end
endmodule // ptrc_core_model
`default_nettype wire

/* File: tb/ptrc_top_tb.sv */
/* self-checking bench of the trace ram controller: apb set-up, ahb
   traffic, branches, watchpoints, packet readback against a model.
   assumes ptrc_pkg, ptrc_core_model and the checker are compiled. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
   $display("ERROR at %0t got %h exp %h", $time, (g), (e)); end end
module ptrc_top_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic hsel, hwrite, hreadyout, hresp, trace_active, cpu_bus_valid;
   logic t_le, t_seq, t_atm, jump, jump_atomic;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] paddr;
   logic [30:0] t_pc, jump_to;
   logic [31:0] pwdata, prdata, haddr, hwdata, hrdata, rd, d;
   logic [31:0] cpu_bus_addr, cpu_bus_data, exp_lo[int], exp_hi[int];
   int n_errors, comparisons, cyc, waits, pos, base, limit, i;
   bit first, rec;
   // ****************************************************************
   // design, core model, clock and timeout
   // ****************************************************************
   ptrc_top i_ptrc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .hsel(hsel),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .haddr(haddr),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .exec_addr_load_enable(t_le), .exec_instr_addr(t_pc),
      .exec_addr_sequential(t_seq), .atomic(t_atm),
      .cpu_bus_valid(cpu_bus_valid), .cpu_bus_addr(cpu_bus_addr),
      .cpu_bus_data(cpu_bus_data), .trace_active(trace_active));
   ptrc_core_model i_ptrc_core_model (.pclk(pclk), .presetn(presetn),
      .jump(jump), .jump_to(jump_to), .jump_atomic(jump_atomic),
      .exec_addr_load_enable(t_le), .exec_instr_addr(t_pc),
      .exec_addr_sequential(t_seq), .atomic(t_atm));
   initial begin
      pclk = 1'h0;
      forever #50 pclk = ~pclk;
   end
   // a hang is cut short well past the expected run length
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         finish_test;
      end
   end
   task finish_test;
      $display("counts: %0d compared, %0d errors", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // one apb transfer, then an idle cycle so no signal is set twice
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= wd;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0; penable <= 1'h0;
      @(posedge pclk);
   endtask
   // single ahb word transfer; waits counts data phase stall cycles
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'h1; htrans <= 2'h2; hwrite <= w; haddr <= a;
      @(posedge pclk);
      while (hreadyout !== 1'h1) @(posedge pclk);
      hsel <= 1'h0; htrans <= 2'h0; hwdata <= wd;
      waits = 0;
      @(posedge pclk);
      while (hreadyout !== 1'h1) begin
         waits++;
         @(posedge pclk);
      end
      rd = hrdata;
   endtask
   // branch; the source is the pc held when the model takes the command
   task jmp(input logic [30:0] dst, input logic a);
      jump <= 1'h1; jump_to <= dst; jump_atomic <= a;
      @(posedge pclk);
      if (rec) begin
         exp_lo[pos] = {t_pc, a};
         exp_hi[pos] = {dst, first};
         first = 1'b0;
         pos = (pos == limit) ? base : pos + 1;
      end
      jump <= 1'h0;
   endtask
   task watch(input logic [31:0] a, input logic [31:0] dat);
      cpu_bus_valid <= 1'h1; cpu_bus_addr <= a; cpu_bus_data <= dat;
      @(posedge pclk);
      cpu_bus_valid <= 1'h0;
      repeat (4) @(posedge pclk);
   endtask
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
      paddr = 8'h0; pwdata = 32'h0; hsel = 1'h0; htrans = 2'h0;
      hwrite = 1'h0; hsize = 3'h2; haddr = 32'h0; hwdata = 32'h0;
      jump = 1'h0; jump_to = 31'h0; jump_atomic = 1'h0; cpu_bus_valid = 1'h0;
      cpu_bus_addr = 32'h0; cpu_bus_data = 32'h0;
      d = $urandom(32'h433A);
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      apb(1'h0, 8'h28, 32'h0);
      `CHK(err, 1'h1)
      `CHK(rd, 32'h0)
      base = 4; limit = 6; pos = 4;
      apb(1'h1, ptrc_pkg::REG_BASE, 32'(base));
      apb(1'h1, ptrc_pkg::REG_LIMIT, 32'(limit));
      apb(1'h1, ptrc_pkg::REG_POS, 32'(pos));
      apb(1'h0, ptrc_pkg::REG_LIMIT, 32'h0);
      `CHK(rd, 32'h6)
      $display("test region setup done");
      d = $urandom;
      ahb(1'h1, 32'h40, d);
      `CHK(waits, 0)
      ahb(1'h0, 32'h40, 32'h0);
      `CHK(rd, d)
      apb(1'h1, ptrc_pkg::REG_CTRL, 32'h2);
      rec = 1'b1; first = 1'b1;
      apb(1'h0, ptrc_pkg::REG_CTRL, 32'h0);
      `CHK(rd[0], 1'h1)
      for (i = 0; i < 4; i++) begin
         jmp(31'($urandom), i[0]);
         repeat (3) @(posedge pclk);
      end
      jmp(31'h7FFF_FFFC, 1'h0);
      repeat (3) @(posedge pclk);
      jmp(31'($urandom), 1'h1);
      d = $urandom;
      ahb(1'h1, 32'h80, d);
      ahb(1'h0, 32'h80, 32'h0);
      `CHK(rd, d)
      $display("test branches and collision done");
      apb(1'h1, ptrc_pkg::REG_CTRL, 32'h4);
      rec = 1'b0;
      `CHK(trace_active, 1'h0)
      jmp(31'($urandom), 1'h0);
      repeat (3) @(posedge pclk);
      apb(1'h0, ptrc_pkg::REG_POS, 32'h0);
      `CHK(rd, 32'(pos))
      apb(1'h1, ptrc_pkg::REG_CMP0_ADDR, 32'h100);
      apb(1'h1, ptrc_pkg::REG_CMP1_ADDR, 32'h200);
      apb(1'h1, ptrc_pkg::REG_CMP1_DATA, 32'hA5);
      apb(1'h1, ptrc_pkg::REG_CMP_CFG, 32'hB5);
      watch(32'h100, 32'h0);
      `CHK(trace_active, 1'h1)
      rec = 1'b1; first = 1'b1;
      for (i = 0; i < 2; i++) begin
         jmp(31'($urandom), 1'h0);
         repeat (3) @(posedge pclk);
      end
      watch(32'h200, 32'h0);
      `CHK(trace_active, 1'h1)
      watch(32'h200, 32'hA5);
      `CHK(trace_active, 1'h0)
      rec = 1'b0;
      $display("test watchpoints done");
      for (i = base; i <= limit; i++) begin
         ahb(1'h0, 32'(8 * i), 32'h0);
         `CHK(rd, exp_lo[i])
         ahb(1'h0, 32'(8 * i + 4), 32'h0);
         `CHK(rd, exp_hi[i])
      end
      $display("test packet readback done");
      finish_test;
   end
endmodule // ptrc_top_tb
bind ptrc_top ptrc_assertions i_ptrc_assertions (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .hreadyout(hreadyout), .hresp(hresp),
   .trace_active(trace_active));
`default_nettype wire
